// file: rtc_alarm_pkg.sv
// constants, types and register map for the alarm, trim and user-byte block
package rtc_alarm_pkg;

  // ==========================================================
  // register map (byte addresses on the internal register port)
  localparam logic [7:0] ADDR_STATUS = 8'h07;
  localparam logic [7:0] ADDR_INT_CTRL = 8'h08;
  localparam logic [7:0] ADDR_ANALOG_TRIM = 8'h0A;
  localparam logic [7:0] ADDR_DIGITAL_TRIM = 8'h0B;
  localparam logic [7:0] ADDR_ALARM_FIRST = 8'h0C;
  localparam logic [7:0] ADDR_ALARM_LAST = 8'h11;
  localparam logic [7:0] ADDR_USER_FIRST = 8'h12;
  localparam logic [7:0] ADDR_USER_LAST = 8'h19;

  // ==========================================================
  // field positions
  localparam int STAT_AUTO_CLR_BIT = 7;
  localparam int STAT_ALARM_BIT = 2;
  localparam int INT_PULSE_SEL_BIT = 7;
  localparam int INT_ALARM_EN_BIT = 6;
  localparam int ALARM_MATCH_EN_BIT = 7;
  localparam int ANALOG_INV_BIT = 5;
  localparam int DIGITAL_SIGN_BIT = 2;
  localparam int BATT_OFS_LSB = 6;

  // ==========================================================
  // reset values
  localparam logic [7:0] ANALOG_TRIM_RST = 8'h00;  // mid-scale load, 12.5 pF
  localparam logic [7:0] DIGITAL_TRIM_RST = 8'h00;
  localparam logic [7:0] BYTE_RST = 8'h00;

  // ==========================================================
  // capacitance in units of 0.25 pF
  localparam logic [7:0] CAP_BASE_Q = 8'h24;      // 9 pF fixed part
  localparam logic [7:0] CAP_INV_TOP_Q = 8'h40;   // 16 pF for inverted top bit
  localparam logic [7:0] CAP_HALF_PF_Q = 8'h02;   // 0.5 pF
  localparam logic [7:0] CAP_ONE_PF_Q = 8'h04;    // 1 pF

  // ==========================================================
  // timing: pulse width on the interrupt pin
  localparam longint CLK_HZ = 250000000;
  localparam longint PULSE_MS = 250;
  localparam longint PULSE_CYCLES = (CLK_HZ * PULSE_MS) / 1000;

  // digital trim step counts (ppm)
  localparam int TRIM_PPM_MID = 40;
  localparam int TRIM_PPM_LOW = 20;

  // ==========================================================
  // running time fields as seen by the comparator
  typedef struct packed {
    logic [7:0] weekday;
    logic [7:0] month;
    logic [7:0] date;
    logic [7:0] hours;
    logic [7:0] minutes;
    logic [7:0] seconds;
  } time_fields_t;

  // register port request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

  // alarm output states
  typedef enum logic [1:0] {
    IRQ_IDLE = 2'b00,
    IRQ_PULSE = 2'b01,
    IRQ_HOLD = 2'b10
  } irq_state_t;

endpackage : rtc_alarm_pkg

// file: rtc_alarm_compare.sv
// per-field alarm comparator over the six comparable time fields
`timescale 1ns/1ns
`default_nettype none
module rtc_alarm_compare
  import rtc_alarm_pkg::*;
#(
  parameter int FIELDS = 6
) (
  // alarm bytes, field 0 = seconds
  input wire logic [FIELDS*8-1:0] alarm_bytes,
  // running time
  input wire logic [FIELDS*8-1:0] time_bytes,
  // result
  output logic match
);

  logic [FIELDS-1:0] field_ok;
  logic [FIELDS-1:0] field_en;

  // ==========================================================
  // a disabled field always agrees; bit 7 is enable, not data
  genvar i;
  for (i = 0; i < FIELDS; i++) begin : g_field
    assign field_en[i] = alarm_bytes[i*8+ALARM_MATCH_EN_BIT];
    assign field_ok[i] = !field_en[i] ||
        (alarm_bytes[i*8 +: 7] == time_bytes[i*8 +: 7]);
  end

  // all enabled fields equal, and at least one enabled
  assign match = (&field_ok) && (|field_en);

endmodule // rtc_alarm_compare
`default_nettype wire

// file: rtc_rate_trim.sv
// digital rate trim: signed ppm correction from the three-bit trim code
`timescale 1ns/1ns
`default_nettype none
module rtc_rate_trim
  import rtc_alarm_pkg::*;
(
  // trim code
  input wire logic [2:0] code,
  // signed correction in ppm
  output logic signed [7:0] ppm
);

  logic [6:0] mag;

  // ==========================================================
  // sign-magnitude: 100 gives zero, range +-60 ppm
  always_comb begin
    mag = 7'h00;
    if (code[1]) begin
      mag = mag + 7'(TRIM_PPM_MID);
    end
    if (code[0]) begin
      mag = mag + 7'(TRIM_PPM_LOW);
    end
    ppm = code[DIGITAL_SIGN_BIT] ? -$signed({1'b0, mag}) : $signed({1'b0, mag});
  end

endmodule // rtc_rate_trim
`default_nettype wire

// file: rtc_alarm_trim.sv
// alarm compare, interrupt pin, trim settings and user bytes of the clock device
//
// Behaviour
// - six-bit analog trim selects load capacitance, default code gives 12.5 pF
// - each pin cap is 9 pF + 16 pF*not(b5) + 8,4,2,1,0.5 pF weights
// - series load spans 4.5 to 20.25 pF in 0.25 pF steps
// - battery offset: 00 none, 01 -0.5, 10 +0.5, 11 +1 pF
// - digital trim alters average counts per second
// - top digital bit is sign, 1 negative; 100 gives zero
// - middle bit 40 ppm, low bit 20 ppm, range +-60 ppm
// - alarm bytes mirror time encoding, bit 7 is match enable
// - no year alarm; six fields comparable
// - alarm fires when all enabled fields equal running time
// - single mode: match sets flag, pin held low until flag clears
// - recurring mode pulses pin on every match
// - recurring mode sets flag each time, pulsing independent of flag
// - with auto clear enabled, status read clears alarm flag
// - alarm evaluated as time advances, at the seconds update
// - eight battery-backed user bytes at 12h to 19h
// - recurring pulse is active low for 250 ms
// - writing the flag can only clear it
// - nonzero frequency code disables alarm, pin carries frequency
`timescale 1ns/1ns
`default_nettype none
module rtc_alarm_trim
  import rtc_alarm_pkg::*;
#(
  parameter longint PULSE_LEN = PULSE_CYCLES,
  parameter int USER_BYTES = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // register port from the serial interface
  input wire reg_req_t req,
  output logic [7:0] rdata,
  // timekeeping
  input wire logic sec_tick,
  input wire time_fields_t now,
  input wire logic on_battery,
  input wire logic freq_wave,
  // interrupt / frequency pin, active low
  output logic irq_n,
  // trim results to the oscillator
  output logic [7:0] load_cap_q,
  output logic signed [7:0] rate_ppm
);

  // ==========================================================
  // registers
  logic [7:0] status_r, status_nxt;
  logic [7:0] int_ctrl_r, int_ctrl_nxt;
  logic [7:0] analog_r, analog_nxt;
  logic [7:0] digital_r, digital_nxt;
  logic [7:0] alarm_r [0:5];
  logic [7:0] alarm_nxt [0:5];
  logic [7:0] user_r [0:USER_BYTES-1];
  logic [7:0] user_nxt [0:USER_BYTES-1];
  logic [47:0] alarm_flat;
  logic match;
  logic fire;
  logic freq_on;
  logic alarm_en;
  logic pulse_sel;
  logic [31:0] pulse_cnt_r, pulse_cnt_nxt;
  irq_state_t irq_state_r, irq_state_nxt;
  logic [7:0] pin_cap;
  logic [7:0] batt_delta;
  logic signed [7:0] ppm_comb;
  logic irq_n_nxt;

  assign freq_on = |int_ctrl_r[3:0];
  assign alarm_en = int_ctrl_r[INT_ALARM_EN_BIT] && !freq_on;
  assign pulse_sel = int_ctrl_r[INT_PULSE_SEL_BIT];

  // ==========================================================
  // comparator: six fields only, no year
  genvar g;
  for (g = 0; g < 6; g++) begin : g_flat
    assign alarm_flat[g*8 +: 8] = alarm_r[g];
  end

  rtc_alarm_compare #(
    .FIELDS(6)
  ) u_cmp (
    .alarm_bytes(alarm_flat),
    .time_bytes(now),
    .match(match)
  );

  // evaluate only on the one-second update, with fresh time
  assign fire = alarm_en && match && sec_tick;

  // ==========================================================
  // digital trim
  rtc_rate_trim u_rate (
    .code(digital_r[2:0]),
    .ppm(ppm_comb)
  );

  // registered so the oscillator sees a glitch-free correction word
  always_ff @(posedge clk) begin
    if (rst) begin
      rate_ppm <= 8'sh00;
    end else begin
      rate_ppm <= ppm_comb;
    end
  end

  // ==========================================================
  // analog load: one pin cap in quarter pF, halved for series pair
  always_comb begin
    pin_cap = CAP_BASE_Q + (analog_r[ANALOG_INV_BIT] ? 8'h00 : CAP_INV_TOP_Q)
        + {1'b0, analog_r[4:0], 2'b00} / 8'h02;
    unique case (analog_r[BATT_OFS_LSB +: 2])
      2'b00: batt_delta = 8'h00;
      2'b01: batt_delta = -CAP_HALF_PF_Q;
      2'b10: batt_delta = CAP_HALF_PF_Q;
      2'b11: batt_delta = CAP_ONE_PF_Q;
    endcase
    if (!on_battery) begin
      batt_delta = 8'h00;
    end
  end

  // series load: 18..81 quarter pF (4.5..20.25 pF), plus battery shift
  always_ff @(posedge clk) begin
    if (rst) begin
      load_cap_q <= 8'h00;
    end else begin
      load_cap_q <= (pin_cap >> 1) + batt_delta;
    end
  end

  // ==========================================================
  // register next values: writes, flag set, read auto clear
  always_comb begin
    status_nxt = status_r;
    int_ctrl_nxt = int_ctrl_r;
    analog_nxt = analog_r;
    digital_nxt = digital_r;
    for (int i = 0; i < 6; i++) begin
      alarm_nxt[i] = alarm_r[i];
    end
    for (int i = 0; i < USER_BYTES; i++) begin
      user_nxt[i] = user_r[i];
    end
    if (req.wr) begin
      unique case (req.addr)
        ADDR_STATUS: begin
          status_nxt[STAT_AUTO_CLR_BIT] = req.wdata[STAT_AUTO_CLR_BIT];
          // flag write may only clear
          status_nxt[STAT_ALARM_BIT] = status_r[STAT_ALARM_BIT]
              & req.wdata[STAT_ALARM_BIT];
        end
        ADDR_INT_CTRL: int_ctrl_nxt = req.wdata;
        ADDR_ANALOG_TRIM: analog_nxt = req.wdata;
        ADDR_DIGITAL_TRIM: digital_nxt = {5'h00, req.wdata[2:0]};
        default: begin
          if (req.addr >= ADDR_ALARM_FIRST && req.addr <= ADDR_ALARM_LAST) begin
            alarm_nxt[3'(req.addr - ADDR_ALARM_FIRST)] = req.wdata;
          end
          if (req.addr >= ADDR_USER_FIRST && req.addr <= ADDR_USER_LAST) begin
            user_nxt[3'(req.addr - ADDR_USER_FIRST)] = req.wdata;
          end
        end
      endcase
    end
    if (req.rd && req.addr == ADDR_STATUS && status_r[STAT_AUTO_CLR_BIT]) begin
      status_nxt[STAT_ALARM_BIT] = 1'b0;
    end
    // a match in the clearing cycle keeps the flag set
    if (fire) begin
      status_nxt[STAT_ALARM_BIT] = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      status_r <= BYTE_RST;
      int_ctrl_r <= BYTE_RST;
      analog_r <= ANALOG_TRIM_RST;
      digital_r <= DIGITAL_TRIM_RST;
      for (int i = 0; i < 6; i++) begin
        alarm_r[i] <= BYTE_RST;
      end
      for (int i = 0; i < USER_BYTES; i++) begin
        user_r[i] <= BYTE_RST;
      end
    end else begin
      status_r <= status_nxt;
      int_ctrl_r <= int_ctrl_nxt;
      analog_r <= analog_nxt;
      digital_r <= digital_nxt;
      alarm_r <= alarm_nxt;
      user_r <= user_nxt;
    end
  end

  // ==========================================================
  // read data, registered
  always_ff @(posedge clk) begin
    if (rst) begin
      rdata <= 8'h00;
    end else if (req.rd) begin
      if (req.addr == ADDR_STATUS) begin
        rdata <= status_r;
      end else if (req.addr == ADDR_INT_CTRL) begin
        rdata <= int_ctrl_r;
      end else if (req.addr == ADDR_ANALOG_TRIM) begin
        rdata <= analog_r;
      end else if (req.addr == ADDR_DIGITAL_TRIM) begin
        rdata <= digital_r;
      end else if (req.addr >= ADDR_ALARM_FIRST && req.addr <= ADDR_ALARM_LAST) begin
        rdata <= alarm_r[3'(req.addr - ADDR_ALARM_FIRST)];
      end else if (req.addr >= ADDR_USER_FIRST && req.addr <= ADDR_USER_LAST) begin
        rdata <= user_r[3'(req.addr - ADDR_USER_FIRST)];
      end else begin
        rdata <= 8'h00;
      end
    end
  end

  // ==========================================================
  // pin state machine: hold in single mode, timed pulse in recurring
  always_comb begin
    irq_state_nxt = irq_state_r;
    pulse_cnt_nxt = pulse_cnt_r;
    unique case (irq_state_r)
      IRQ_IDLE: begin
        if (fire && pulse_sel) begin
          irq_state_nxt = IRQ_PULSE;
          pulse_cnt_nxt = 32'(PULSE_LEN - 1);
        end else if (alarm_en && !pulse_sel && status_r[STAT_ALARM_BIT]) begin
          irq_state_nxt = IRQ_HOLD;
        end
      end
      IRQ_PULSE: begin
        if (!alarm_en) begin
          irq_state_nxt = IRQ_IDLE;
        end else if (pulse_cnt_r == 32'h0000_0000) begin
          irq_state_nxt = IRQ_IDLE;
        end else begin
          pulse_cnt_nxt = pulse_cnt_r - 32'h0000_0001;
        end
      end
      IRQ_HOLD: begin
        // released once the flag clears or the mode changes
        if (!status_r[STAT_ALARM_BIT] || !alarm_en || pulse_sel) begin
          irq_state_nxt = IRQ_IDLE;
        end
      end
      default: irq_state_nxt = IRQ_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      irq_state_r <= IRQ_IDLE;
      pulse_cnt_r <= 32'h0000_0000;
    end else begin
      irq_state_r <= irq_state_nxt;
      pulse_cnt_r <= pulse_cnt_nxt;
    end
  end

  // frequency output overrides the alarm on the shared pin
  always_comb begin
    if (freq_on) begin
      irq_n_nxt = freq_wave;
    end else begin
      irq_n_nxt = (irq_state_nxt == IRQ_IDLE);
    end
  end

  // pin registered so it never glitches while the state decodes
  always_ff @(posedge clk) begin
    if (rst) begin
      irq_n <= 1'b1;
    end else begin
      irq_n <= irq_n_nxt;
    end
  end

  // ==========================================================
  // checks
  flag_set_a: assert property (@(posedge clk) disable iff (rst)
      fire |=> status_r[STAT_ALARM_BIT]) else $error("flag not set on match");
  flag_write_a: assert property (@(posedge clk) disable iff (rst)
      (!status_r[STAT_ALARM_BIT] && !fire) |=> !status_r[STAT_ALARM_BIT])
      else $error("flag rose without match");
  auto_clear_a: assert property (@(posedge clk) disable iff (rst)
      (req.rd && req.addr == ADDR_STATUS && status_r[STAT_AUTO_CLR_BIT] && !fire && !req.wr)
      |=> !status_r[STAT_ALARM_BIT]) else $error("auto clear failed");
  tick_only_a: assert property (@(posedge clk) disable iff (rst)
      !sec_tick |-> !fire) else $error("fire off tick");
  freq_block_a: assert property (@(posedge clk) disable iff (rst)
      freq_on |-> !fire) else $error("alarm fired with frequency on");
  pulse_low_a: assert property (@(posedge clk) disable iff (rst)
      (fire && pulse_sel && irq_state_r == IRQ_IDLE && !freq_on) |=> !irq_n [*8])
      else $error("pulse too short");
  hold_low_a: assert property (@(posedge clk) disable iff (rst)
      (irq_state_r == IRQ_HOLD && status_r[STAT_ALARM_BIT] && !freq_on && !pulse_sel
       && alarm_en) |=> !irq_n) else $error("hold released early");
  // enable bits only: data bits alone must never let the alarm fire
  match_need_a: assert property (@(posedge clk) disable iff (rst)
      fire |-> (|{alarm_r[5][ALARM_MATCH_EN_BIT], alarm_r[4][ALARM_MATCH_EN_BIT],
                  alarm_r[3][ALARM_MATCH_EN_BIT], alarm_r[2][ALARM_MATCH_EN_BIT],
                  alarm_r[1][ALARM_MATCH_EN_BIT], alarm_r[0][ALARM_MATCH_EN_BIT]}))
      else $error("fire with no field enabled");
  cap_range_a: assert property (@(posedge clk) disable iff (rst)
      !on_battery |=> (load_cap_q >= 8'h12 && load_cap_q <= 8'h51))
      else $error("load out of range");
  pulse_end_a: assert property (@(posedge clk) disable iff (rst)
      (irq_state_r == IRQ_PULSE && pulse_cnt_r == 32'h0000_0000 && !freq_on) |=> irq_n)
      else $error("pulse not released");
  user_write_a: assert property (@(posedge clk) disable iff (rst)
      (req.wr && req.addr == ADDR_USER_FIRST) |=> (user_r[0] == $past(req.wdata)))
      else $error("user byte not written");
  sign_zero_a: assert property (@(posedge clk) disable iff (rst)
      (digital_r[2:0] == 3'h4) |=> (rate_ppm == 8'sh00))
      else $error("negative zero code not zero");

  single_c: cover property (@(posedge clk) irq_state_r == IRQ_HOLD);
  pulse_c: cover property (@(posedge clk) irq_state_r == IRQ_PULSE ##1 irq_state_r == IRQ_IDLE);
  clear_c: cover property (@(posedge clk) status_r[STAT_ALARM_BIT] ##1 !status_r[STAT_ALARM_BIT]);
  battery_c: cover property (@(posedge clk) on_battery && analog_r[BATT_OFS_LSB +: 2] == 2'b01);
  auto_read_c: cover property (@(posedge clk) req.rd && req.addr == ADDR_STATUS
      && status_r[STAT_AUTO_CLR_BIT] && status_r[STAT_ALARM_BIT]);

endmodule // rtc_alarm_trim
`default_nettype wire

// file: host_model.sv
// host-side driver of the register port of the alarm and trim block
`timescale 1ns/1ns
`default_nettype none
module host_model
  import rtc_alarm_pkg::*;
(
  // clock
  input wire logic clk,
  // register port toward the device
  output var reg_req_t req
);
  // ==========================================================
  // accesses
  // port idle from time zero, so nothing is taken during reset
  initial begin
    req = '0;
  end

  // one-cycle write; an idle edge follows so strobes never collide
  task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk);
    req <= '0;
  endtask

  // one-cycle read; the bench watcher picks the data up an edge later
  task automatic read_reg(input logic [7:0] a);
    @(posedge clk);
    req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clk);
    req <= '0;
  endtask
endmodule // host_model
`default_nettype wire

// file: testbench.sv
// self-checking bench for the alarm, trim and user-byte block
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, ex, got) begin compares++; if ((got) !== (ex)) begin n_mismatch++; $display("mismatch %s expected %h seen %h", nm, ex, got); end end
module testbench
  import rtc_alarm_pkg::*;
;
  // ==========================================================
  // signals
  logic clk = 1'b0;
  logic rst = 1'b1;
  reg_req_t req;
  logic [7:0] rdata;
  logic sec_tick = 1'b0;
  time_fields_t now = '0;
  logic on_battery = 1'b0;
  logic freq_wave = 1'b0;
  logic irq_n;
  logic [7:0] load_cap_q;
  logic signed [7:0] rate_ppm;
  logic [7:0] exp_q[$];
  logic [7:0] e;
  logic [7:0] ub [8];
  logic [7:0] al [6] = '{8'h00, 8'hB0, 8'h91, 8'h81, 8'h81, 8'h00};
  logic rd_d = 1'b0;
  logic [15:0] lfsr = 16'hA48F;
  int n_mismatch = 0;
  int compares = 0;

  host_model i_host_model (.clk(clk), .req(req));
  // short pulse length keeps the recurring-mode scenarios quick
  rtc_alarm_trim #(.PULSE_LEN(16)) i_rtc_alarm_trim (.clk(clk), .rst(rst), .req(req),
    .rdata(rdata), .sec_tick(sec_tick), .now(now), .on_battery(on_battery),
    .freq_wave(freq_wave), .irq_n(irq_n), .load_cap_q(load_cap_q), .rate_ppm(rate_ppm));

  // 250 MHz
  initial begin
    forever #2 clk = ~clk;
  end

  // ==========================================================
  // helpers
  function automatic logic [15:0] lfsr_step(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  // series load in quarter pF: half of one pin cap, plus battery delta
  function automatic logic [7:0] cap_exp(input logic [5:0] c, input logic [1:0] b,
                                         input logic bat);
    logic [7:0] x;
    x = ((c[5] ? 8'h00 : 8'h40) + {2'b00, c[4:0], 1'b0} + 8'h24) >> 1;
    if (bat) x = x + ((b == 2'b01) ? 8'hFE : (b == 2'b10) ? 8'h02 : {5'h00, b[0], 2'b00});
    return x;
  endfunction

  function automatic logic signed [7:0] ppm_exp(input logic [2:0] c);
    logic signed [7:0] m;
    m = (c[1] ? 8'sh28 : 8'sh00) + (c[0] ? 8'sh14 : 8'sh00);
    return c[2] ? -m : m;
  endfunction

  task automatic rd(input logic [7:0] a, input logic [7:0] x);
    exp_q.push_back(x);
    i_host_model.read_reg(a);
  endtask

  // new time fields with a one-cycle update strobe
  task automatic tick(input logic [7:0] mn, input logic [7:0] sc);
    @(posedge clk);
    now <= '{8'h03, 8'h01, 8'h01, 8'h11, mn, sc};
    sec_tick <= 1'b1;
    @(posedge clk);
    sec_tick <= 1'b0;
  endtask

  // pin level once the two-stage single-mode latency has passed
  task automatic pin_is(input logic x);
    repeat (3) @(posedge clk);
    #1;
    `CHK("irq_n", x, irq_n)
  endtask

  // bounded window wider than the pulse, so a stuck pin shows as a wrong count
  task automatic pulse_check;
    int n;
    n = 0;
    // first sample lands in the cycle the pin drops, just after the tick edge
    repeat (30) begin
      #1;
      if (irq_n === 1'b0) n++;
      @(posedge clk);
    end
    `CHK("pulse cycles", 16, n)
  endtask

  task automatic wrap_up;
    if (n_mismatch == 0 && compares > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // ==========================================================
  // read watcher: oldest note against the data of the previous read
  always @(posedge clk) begin
    if (rd_d) begin
      e = (exp_q.size() != 0) ? exp_q.pop_front() : 8'hxx;
      `CHK("rdata", e, rdata)
    end
    rd_d <= req.rd;
  end

  // a hang ends the run as a failure
  initial begin
    repeat (20000) @(posedge clk);
    `CHK("run length", 1'b0, 1'b1)
    wrap_up;
  end

  // ==========================================================
  // main sequence
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    rd(ADDR_ANALOG_TRIM, 8'h00);
    rd(ADDR_DIGITAL_TRIM, 8'h00);
    `CHK("load_cap_q", 8'h32, load_cap_q)
    // all user bytes written before any readback, to catch aliasing
    for (int i = 0; i < 8; i++) begin
      lfsr = lfsr_step(lfsr);
      ub[i] = lfsr[7:0];
      i_host_model.write_reg(ADDR_USER_FIRST + 8'(i), ub[i]);
    end
    for (int i = 0; i < 8; i++) rd(ADDR_USER_FIRST + 8'(i), ub[i]);
    i_host_model.write_reg(8'h1A, 8'hA5);
    rd(8'h1A, 8'h00);
    // every analog code, random battery offset and supply
    for (int c = 0; c < 64; c++) begin
      lfsr = lfsr_step(lfsr);
      @(posedge clk);
      on_battery <= lfsr[8];
      i_host_model.write_reg(ADDR_ANALOG_TRIM, {lfsr[1:0], 6'(c)});
      rd(ADDR_ANALOG_TRIM, {lfsr[1:0], 6'(c)});
      @(posedge clk);
      #1;
      `CHK("load_cap_q", cap_exp(6'(c), lfsr[1:0], lfsr[8]), load_cap_q)
    end
    @(posedge clk);
    on_battery <= 1'b0;
    for (int c = 0; c < 8; c++) begin
      i_host_model.write_reg(ADDR_DIGITAL_TRIM, 8'(c));
      @(posedge clk);
      #1;
      `CHK("rate_ppm", ppm_exp(3'(c)), rate_ppm)
    end
    // single event at 11:30 on the first of the first month
    for (int i = 0; i < 6; i++) i_host_model.write_reg(ADDR_ALARM_FIRST + 8'(i), al[i]);
    i_host_model.write_reg(ADDR_INT_CTRL, 8'h40);
    tick(8'h29, 8'h59);
    pin_is(1'b1);
    @(posedge clk);
    now <= '{8'h03, 8'h01, 8'h01, 8'h11, 8'h30, 8'h00};
    pin_is(1'b1);
    tick(8'h30, 8'h00);
    pin_is(1'b0);
    rd(ADDR_STATUS, 8'h04);
    i_host_model.write_reg(ADDR_STATUS, 8'h04);
    rd(ADDR_STATUS, 8'h04);
    pin_is(1'b0);
    i_host_model.write_reg(ADDR_STATUS, 8'h00);
    rd(ADDR_STATUS, 8'h00);
    pin_is(1'b1);
    // flag cleared by the read itself
    i_host_model.write_reg(ADDR_STATUS, 8'h80);
    tick(8'h30, 8'h00);
    pin_is(1'b0);
    rd(ADDR_STATUS, 8'h84);
    rd(ADDR_STATUS, 8'h80);
    pin_is(1'b1);
    // recurring: second pulse with the flag still standing
    i_host_model.write_reg(ADDR_INT_CTRL, 8'hC0);
    tick(8'h30, 8'h00);
    pulse_check;
    tick(8'h30, 8'h00);
    pulse_check;
    rd(ADDR_STATUS, 8'h84);
    // frequency output takes the pin and silences the alarm
    i_host_model.write_reg(ADDR_INT_CTRL, 8'h41);
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      freq_wave <= i[0];
      pin_is(i[0]);
    end
    tick(8'h30, 8'h00);
    pin_is(1'b1);
    rd(ADDR_STATUS, 8'h80);
    repeat (2) @(posedge clk);
    `CHK("pending reads", 0, exp_q.size())
    wrap_up;
  end
endmodule // testbench
`default_nettype wire
